// *** oscillator_switch_control_bench.sv ***
`include "oscsw_defines.vh"
module oscillator_switch_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic MCLK = 1'h0, ARST_N = 1'h0, SYS_RST_N = 1'h1;
    logic [3:0] S_AXI_AWADDR = 4'h0, S_AXI_ARADDR = 4'h0, S_AXI_WSTRB = 4'h3;
    logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rd;
    logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
    logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0, S_AXI_AWREADY;
    logic S_AXI_WREADY, S_AXI_ARREADY, S_AXI_BVALID, S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rr, rb;
    logic [2:0] CURRENT_SOURCE = 3'h5, NEW_SOURCE_SELECT;
    logic SWITCH_DONE = 1'h0, CLOCK_FAIL = 1'h0, PLL_LOCKED = 1'h0;
    logic PLL_TIMER_BUSY = 1'h0, PLL_ENABLED = 1'h0, PIN_SELECT_WE = 1'h1;
    logic PIN_SELECT_WE_OK, SWITCH_REQUEST, SECONDARY_OSC_ENABLE;
    logic CLOCK_SOURCE_LOCK, PIN_REMAP_LOCK, CLOCK_FAIL_FLAG;
    int fails = 0, compares = 0, cyc = 0;
    // a non-zero power-up source shows that the configured value is kept
    oscsw_ctrl #(.NSEL_INIT(3'h2)) u_oscsw_ctrl (
        .MCLK(MCLK), .ARST_N(ARST_N), .SYS_RST_N(SYS_RST_N),
        .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
        .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
        .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
        .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
        .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
        .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
        .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
        .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
        .S_AXI_RREADY(S_AXI_RREADY), .CURRENT_SOURCE(CURRENT_SOURCE),
        .SWITCH_DONE(SWITCH_DONE), .CLOCK_FAIL(CLOCK_FAIL),
        .PLL_LOCKED(PLL_LOCKED), .PLL_TIMER_BUSY(PLL_TIMER_BUSY),
        .PLL_ENABLED(PLL_ENABLED), .PIN_SELECT_WE(PIN_SELECT_WE),
        .PIN_SELECT_WE_OK(PIN_SELECT_WE_OK),
        .NEW_SOURCE_SELECT(NEW_SOURCE_SELECT),
        .SWITCH_REQUEST(SWITCH_REQUEST),
        .SECONDARY_OSC_ENABLE(SECONDARY_OSC_ENABLE),
        .CLOCK_SOURCE_LOCK(CLOCK_SOURCE_LOCK),
        .PIN_REMAP_LOCK(PIN_REMAP_LOCK),
        .CLOCK_FAIL_FLAG(CLOCK_FAIL_FLAG)
    );
    always #20 MCLK = ~MCLK;
    // whole run needs well under 3000 cycles
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 6000) begin
            fails++;
            stop_test();
        end
    end
    task stop_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk_w(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t word %h exp %h", $time, got, exp);
        end
    endtask
    task chk_b(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t flag %b exp %b", $time, got, exp);
        end
    endtask
    // the leading edge keeps a release and a new request apart
    task wr(input logic [3:0] a, input logic [15:0] d);
        logic ga, gw;
        ga = 1'h0;
        gw = 1'h0;
        @(posedge MCLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= {16'h0, d};
        S_AXI_AWVALID <= 1'h1;
        S_AXI_WVALID <= 1'h1;
        S_AXI_BREADY <= 1'h1;
        while (!(ga && gw)) begin
            @(posedge MCLK);
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                ga = 1'h1;
                S_AXI_AWVALID <= 1'h0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                gw = 1'h1;
                S_AXI_WVALID <= 1'h0;
            end
        end
        while (!S_AXI_BVALID) @(posedge MCLK);
        rb = S_AXI_BRESP;
        S_AXI_BREADY <= 1'h0;
    endtask
    task rdr(input logic [3:0] a);
        @(posedge MCLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'h1;
        S_AXI_RREADY <= 1'h1;
        do @(posedge MCLK); while (!S_AXI_ARREADY);
        S_AXI_ARVALID <= 1'h0;
        do @(posedge MCLK); while (!S_AXI_RVALID);
        rd = S_AXI_RDATA;
        rr = S_AXI_RRESP;
        S_AXI_RREADY <= 1'h0;
    endtask
    task uwr(input logic [15:0] d);
        wr(4'h4, `OSCSW_KEY1);
        wr(4'h4, `OSCSW_KEY2);
        wr(4'h0, d);
    endtask
    task t_lock();
        rdr(4'h0);
        chk_w(rd, 32'h5200);
        wr(4'h0, 16'h0102);
        chk_w({30'h0, rb}, 32'h0);
        rdr(4'h0);
        chk_w(rd, 32'h5200);
        uwr(16'h0102);
        rdr(4'h0);
        chk_w(rd, 32'h5102);
        chk_b(SECONDARY_OSC_ENABLE, 1'h1);
        for (int i = 0; i < 8; i++) begin
            uwr({5'h0, i[2:0], 8'h0});
            chk_w({29'h0, NEW_SOURCE_SELECT}, i);
        end
        chk_b(SECONDARY_OSC_ENABLE, 1'h0);
        // an unused unlock closes by itself after eight cycles
        wr(4'h4, `OSCSW_KEY1);
        wr(4'h4, `OSCSW_KEY2);
        rdr(4'h8);
        chk_w(rd, 32'h1);
        repeat (8) @(posedge MCLK);
        rdr(4'h8);
        chk_w(rd, 32'h0);
        wr(4'h0, 16'h0002);
        rdr(4'h0);
        chk_w(rd, 32'h5700);
        $display("t_lock done");
    endtask
    task t_switch();
        uwr(16'h0001);
        chk_b(SWITCH_REQUEST, 1'h1);
        SWITCH_DONE <= 1'h1;
        @(posedge MCLK);
        SWITCH_DONE <= 1'h0;
        @(posedge MCLK);
        chk_b(SWITCH_REQUEST, 1'h0);
        CLOCK_FAIL <= 1'h1;
        @(posedge MCLK);
        CLOCK_FAIL <= 1'h0;
        @(posedge MCLK);
        chk_b(CLOCK_FAIL_FLAG, 1'h1);
        uwr(16'h0008);
        chk_b(CLOCK_FAIL_FLAG, 1'h1);
        uwr(16'h0000);
        chk_b(CLOCK_FAIL_FLAG, 1'h0);
        $display("t_switch done");
    endtask
    task t_misc();
        for (int i = 0; i < 8; i++) begin
            {PLL_LOCKED, PLL_ENABLED, PLL_TIMER_BUSY} <= i[2:0];
            rdr(4'h0);
            chk_b(rd[5], i == 6);
        end
        uwr(16'h0040);
        chk_b(PIN_SELECT_WE_OK, 1'h0);
        chk_b(PIN_REMAP_LOCK, 1'h1);
        uwr(16'h0000);
        chk_b(PIN_SELECT_WE_OK, 1'h1);
        PIN_SELECT_WE <= 1'h0;
        @(posedge MCLK);
        chk_b(PIN_SELECT_WE_OK, 1'h0);
        PIN_SELECT_WE <= 1'h1;
        uwr(16'h0b36);
        rdr(4'h0);
        chk_w(rd, 32'h5302);
        rdr(4'hc);
        chk_w({30'h0, rr}, 32'h2);
        wr(4'hc, 16'h0000);
        chk_w({30'h0, rb}, 32'h2);
        SYS_RST_N <= 1'h0;
        repeat (3) @(posedge MCLK);
        SYS_RST_N <= 1'h1;
        rdr(4'h0);
        chk_w(rd, 32'h5302);
        // the source lock blocks source and request writes until power-on
        uwr(16'h0080);
        uwr(16'h0701);
        rdr(4'h0);
        chk_w(rd, 32'h5080);
        chk_b(CLOCK_SOURCE_LOCK, 1'h1);
        ARST_N <= 1'h0;
        repeat (3) @(posedge MCLK);
        ARST_N <= 1'h1;
        rdr(4'h0);
        chk_w(rd, 32'h5200);
        chk_b(CLOCK_SOURCE_LOCK, 1'h0);
        $display("t_misc done");
    endtask
    initial begin
        repeat (10) @(posedge MCLK);
        ARST_N <= 1'h1;
        t_lock();
        t_switch();
        t_misc();
        stop_test();
    end
endmodule

// *** oscsw_ctrl.v ***
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`include "oscsw_defines.vh"
// Notes on behaviour
// - software sets the switch request to move to the selected source and hardware clears it when the switch is done.
// - a detected clock failure sets a sticky fail flag that software can only clear.
// - the secondary enable bit turns the secondary oscillator on when 1 and off when 0.
// - control register writes only take effect right after the unlock sequence.
// - the control register returns to reset values only on power-on reset.
// - bits 11, 4 and 2 always read zero.
module oscsw_ctrl #(
    parameter [2:0] NSEL_INIT = 3'h0
) (
    input wire MCLK,
    input wire ARST_N,
    input wire SYS_RST_N,
    input wire [3:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output wire S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output wire S_AXI_WREADY,
    output wire [1:0] S_AXI_BRESP,
    output wire S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [3:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output wire S_AXI_ARREADY,
    output wire [31:0] S_AXI_RDATA,
    output wire [1:0] S_AXI_RRESP,
    output wire S_AXI_RVALID,
    input wire S_AXI_RREADY,
    input wire [2:0] CURRENT_SOURCE,
    input wire SWITCH_DONE,
    input wire CLOCK_FAIL,
    input wire PLL_LOCKED,
    input wire PLL_TIMER_BUSY,
    input wire PLL_ENABLED,
    input wire PIN_SELECT_WE,
    output wire PIN_SELECT_WE_OK,
    output wire [2:0] NEW_SOURCE_SELECT,
    output wire SWITCH_REQUEST,
    output wire SECONDARY_OSC_ENABLE,
    output wire CLOCK_SOURCE_LOCK,
    output wire PIN_REMAP_LOCK,
    output wire CLOCK_FAIL_FLAG
);
    reg [31:0] awaddr_reg;
    reg aw_full_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;
    reg w_full_reg;
    reg bvalid_reg;
    reg [1:0] bresp_reg;
    reg rvalid_reg;
    reg [31:0] rdata_reg;
    reg [1:0] rresp_reg;
    reg [2:0] nsel_reg;
    reg req_reg;
    reg secen_reg;
    reg clklk_reg;
    reg remap_reg;
    reg fail_reg;
    reg [15:0] ctrl_rd;
    wire wr_go;
    wire wr_ctrl;
    wire wr_key;
    wire key_open;
    wire [15:0] wd16;
    wire lo_en;
    wire hi_en;

    function [15:0] merge16;
        input [15:0] old;
        input [15:0] nw;
        input [1:0] strb;
        begin
            merge16 = {strb[1] ? nw[15:8] : old[15:8],
                       strb[0] ? nw[7:0] : old[7:0]};
        end
    endfunction

    assign S_AXI_AWREADY = !aw_full_reg;
    assign S_AXI_WREADY = !w_full_reg;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;
    assign S_AXI_ARREADY = !rvalid_reg;
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RDATA = rdata_reg;
    assign S_AXI_RRESP = rresp_reg;

    assign wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wr_ctrl = wr_go && awaddr_reg[3:0] == `OSCSW_ADDR_CTRL;
    assign wr_key = wr_go && awaddr_reg[3:0] == `OSCSW_ADDR_UNLOCK;
    assign wd16 = merge16(ctrl_rd, wdata_reg[15:0], wstrb_reg[1:0]);
    assign lo_en = wr_ctrl && key_open && wstrb_reg[0];
    assign hi_en = wr_ctrl && key_open && wstrb_reg[1];

    oscsw_keyseq u_keyseq (
        .clk(MCLK),
        .arst_n(ARST_N),
        .key_we(wr_key),
        .key_data(wdata_reg[15:0]),
        .consume(wr_ctrl),
        .open(key_open)
    );

    always @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            aw_full_reg <= 1'b0;
            awaddr_reg <= 32'h0;
            w_full_reg <= 1'b0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
        end else begin
            if (S_AXI_AWVALID && !aw_full_reg) begin
                aw_full_reg <= 1'b1;
                awaddr_reg <= {28'h0, S_AXI_AWADDR};
            end
            if (S_AXI_WVALID && !w_full_reg) begin
                w_full_reg <= 1'b1;
                wdata_reg <= S_AXI_WDATA;
                wstrb_reg <= S_AXI_WSTRB;
            end
            if (wr_go) begin
                bvalid_reg <= 1'b1;
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                if (awaddr_reg[3:0] == `OSCSW_ADDR_CTRL ||
                    awaddr_reg[3:0] == `OSCSW_ADDR_UNLOCK ||
                    awaddr_reg[3:0] == `OSCSW_ADDR_STATUS) begin
                    bresp_reg <= 2'h0;
                end else begin
                    bresp_reg <= 2'h2;
                end
            end else if (bvalid_reg && S_AXI_BREADY) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            // the source field powers up at the configured value
            nsel_reg <= NSEL_INIT;
            req_reg <= 1'b0;
            secen_reg <= 1'b0;
            clklk_reg <= 1'b0;
            remap_reg <= 1'b0;
            fail_reg <= 1'b0;
        end else begin
            if (hi_en && !clklk_reg) begin
                nsel_reg <= wd16[`OSCSW_NSEL_HI:`OSCSW_NSEL_LO];
            end
            if (lo_en) begin
                secen_reg <= wd16[`OSCSW_BIT_SECEN];
                remap_reg <= wd16[`OSCSW_BIT_REMAP];
                // lock bit is sticky until power-on reset
                clklk_reg <= clklk_reg | wd16[`OSCSW_BIT_CLKLK];
            end
            if (SWITCH_DONE && req_reg) begin
                req_reg <= 1'b0;
            end else if (lo_en && !clklk_reg) begin
                req_reg <= wd16[`OSCSW_BIT_REQ];
            end
            if (CLOCK_FAIL) begin
                fail_reg <= 1'b1;
            end else if (lo_en && !wdata_reg[`OSCSW_BIT_FAIL]) begin
                fail_reg <= 1'b0;
            end
        end
    end

    always @* begin
        ctrl_rd = 16'h0;
        ctrl_rd[`OSCSW_CUR_HI:`OSCSW_CUR_LO] = CURRENT_SOURCE;
        ctrl_rd[`OSCSW_NSEL_HI:`OSCSW_NSEL_LO] = nsel_reg;
        ctrl_rd[`OSCSW_BIT_CLKLK] = clklk_reg;
        ctrl_rd[`OSCSW_BIT_REMAP] = remap_reg;
        ctrl_rd[`OSCSW_BIT_PLLLK] = PLL_LOCKED && PLL_ENABLED &&
            !PLL_TIMER_BUSY;
        ctrl_rd[`OSCSW_BIT_FAIL] = fail_reg;
        ctrl_rd[`OSCSW_BIT_SECEN] = secen_reg;
        ctrl_rd[`OSCSW_BIT_REQ] = req_reg;
        ctrl_rd[11] = 1'b0;
        ctrl_rd[4] = 1'b0;
        ctrl_rd[2] = 1'b0;
    end

    always @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= 2'h0;
        end else if (S_AXI_ARVALID && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= 2'h0;
            case (S_AXI_ARADDR)
                `OSCSW_ADDR_CTRL: rdata_reg <= {16'h0, ctrl_rd};
                `OSCSW_ADDR_UNLOCK: rdata_reg <= 32'h0;
                `OSCSW_ADDR_STATUS: rdata_reg <= {31'h0, key_open};
                default: begin
                    rdata_reg <= 32'h0;
                    rresp_reg <= 2'h2;
                end
            endcase
        end else if (rvalid_reg && S_AXI_RREADY) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign NEW_SOURCE_SELECT = nsel_reg;
    assign SWITCH_REQUEST = req_reg;
    assign SECONDARY_OSC_ENABLE = secen_reg;
    assign CLOCK_SOURCE_LOCK = clklk_reg;
    assign PIN_REMAP_LOCK = remap_reg;
    assign CLOCK_FAIL_FLAG = fail_reg;
    assign PIN_SELECT_WE_OK = PIN_SELECT_WE && !remap_reg;

    // SYS_RST_N is deliberately not used: only power-on clears the register
    wire unused_sys_rst = SYS_RST_N;
endmodule

// *** oscsw_defines.vh ***
`ifndef OSCSW_DEFINES_VH
`define OSCSW_DEFINES_VH
// byte addresses on the register bus
`define OSCSW_ADDR_CTRL 4'h0
`define OSCSW_ADDR_UNLOCK 4'h4
`define OSCSW_ADDR_STATUS 4'h8
// unlock keys, written in this order to the unlock word
`define OSCSW_KEY1 16'h0046
`define OSCSW_KEY2 16'h0057
// control register field positions
`define OSCSW_BIT_REQ 0
`define OSCSW_BIT_SECEN 1
`define OSCSW_BIT_FAIL 3
`define OSCSW_BIT_PLLLK 5
`define OSCSW_BIT_REMAP 6
`define OSCSW_BIT_CLKLK 7
`define OSCSW_NSEL_LO 8
`define OSCSW_NSEL_HI 10
`define OSCSW_CUR_LO 12
`define OSCSW_CUR_HI 14
// source codes
`define OSCSW_SRC_FRC 3'h0
`define OSCSW_SRC_FAST_INTERNAL_RC_WITH_MULTIPLIER 3'h1
`define OSCSW_SRC_PRI 3'h2
`define OSCSW_SRC_PRIPLL 3'h3
`define OSCSW_SRC_SEC 3'h4
`define OSCSW_SRC_LOW_POWER_INTERNAL_RC 3'h5
`define OSCSW_SRC_FRC16 3'h6
`define OSCSW_SRC_FRCN 3'h7
// cycles the unlock stays open after the second key
`define OSCSW_UNLOCK_CYC 4'h8
`endif

// *** oscsw_keyseq.v ***
`include "oscsw_defines.vh"
// unlock sequencer: two keys in order open a short write window
module oscsw_keyseq (
    input wire clk,
    input wire arst_n,
    input wire key_we,
    input wire [15:0] key_data,
    input wire consume,
    output wire open
);
    reg [1:0] st_reg;
    reg [1:0] st_next;
    reg [3:0] cnt_reg;
    reg [3:0] cnt_next;
    localparam S_IDLE = 2'h0;
    localparam S_KEY1 = 2'h1;
    localparam S_OPEN = 2'h2;

    assign open = (st_reg == S_OPEN);

    always @* begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        case (st_reg)
            S_IDLE: begin
                if (key_we && key_data == `OSCSW_KEY1) begin
                    st_next = S_KEY1;
                end
            end
            S_KEY1: begin
                if (key_we) begin
                    if (key_data == `OSCSW_KEY2) begin
                        st_next = S_OPEN;
                        cnt_next = `OSCSW_UNLOCK_CYC;
                    end else begin
                        st_next = S_IDLE;
                    end
                end
            end
            S_OPEN: begin
                // one write per unlock; the window also times out
                if (consume || cnt_reg == 4'h1) begin
                    st_next = S_IDLE;
                end
                cnt_next = cnt_reg - 4'h1;
            end
            default: begin
                st_next = S_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= S_IDLE;
            cnt_reg <= 4'h0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule

// *** oscsw_monitor.sv ***
module oscsw_monitor (
    input logic MCLK,
    input logic ARST_N,
    input logic SWITCH_DONE,
    input logic CLOCK_FAIL,
    input logic PIN_SELECT_WE,
    input logic PIN_SELECT_WE_OK,
    input logic PIN_REMAP_LOCK,
    input logic S_AXI_BVALID,
    input logic S_AXI_RVALID,
    input logic [31:0] S_AXI_RDATA,
    input logic [2:0] NEW_SOURCE_SELECT,
    input logic SWITCH_REQUEST,
    input logic SECONDARY_OSC_ENABLE,
    input logic CLOCK_FAIL_FLAG
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!ARST_N);
    // software fields may only move on the edge a write response rises
    sequence s_wr;
        $rose(S_AXI_BVALID);
    endsequence
    property p_req_set;
        $rose(SWITCH_REQUEST) |-> s_wr;
    endproperty
    property p_req_done;
        SWITCH_REQUEST && SWITCH_DONE |=> !SWITCH_REQUEST;
    endproperty
    property p_fail_set;
        CLOCK_FAIL |=> CLOCK_FAIL_FLAG;
    endproperty
    property p_fail_clr;
        $fell(CLOCK_FAIL_FLAG) |-> s_wr;
    endproperty
    property p_src;
        $changed(NEW_SOURCE_SELECT) |-> s_wr;
    endproperty
    property p_sec;
        $changed(SECONDARY_OSC_ENABLE) |-> s_wr;
    endproperty
    property p_remap;
        PIN_SELECT_WE_OK == (PIN_SELECT_WE && !PIN_REMAP_LOCK);
    endproperty
    property p_rsvd;
        S_AXI_RVALID |-> !(S_AXI_RDATA[11] | S_AXI_RDATA[4] | S_AXI_RDATA[2]);
    endproperty
    a_req_set: assert property (p_req_set)
        else $error("request rose without a write");
    a_req_done: assert property (p_req_done)
        else $error("request not cleared by done");
    a_fail_set: assert property (p_fail_set)
        else $error("fail flag not set");
    a_fail_clr: assert property (p_fail_clr)
        else $error("fail flag cleared without a write");
    a_src: assert property (p_src)
        else $error("source field moved without a write");
    a_sec: assert property (p_sec)
        else $error("secondary enable moved without a write");
    a_remap: assert property (p_remap)
        else $error("pin select gate wrong");
    a_rsvd: assert property (p_rsvd)
        else $error("unimplemented bit reads one");
endmodule
bind oscsw_ctrl oscsw_monitor u_oscsw_monitor (
    .MCLK(MCLK),
    .ARST_N(ARST_N),
    .SWITCH_DONE(SWITCH_DONE),
    .CLOCK_FAIL(CLOCK_FAIL),
    .PIN_SELECT_WE(PIN_SELECT_WE),
    .PIN_SELECT_WE_OK(PIN_SELECT_WE_OK),
    .PIN_REMAP_LOCK(PIN_REMAP_LOCK),
    .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RDATA(S_AXI_RDATA),
    .NEW_SOURCE_SELECT(NEW_SOURCE_SELECT),
    .SWITCH_REQUEST(SWITCH_REQUEST),
    .SECONDARY_OSC_ENABLE(SECONDARY_OSC_ENABLE),
    .CLOCK_FAIL_FLAG(CLOCK_FAIL_FLAG)
);
